// File: inc/throttle_defines.svh
`ifndef THROTTLE_DEFINES_SVH
`define THROTTLE_DEFINES_SVH

// Register byte offsets
`define TPM_OFF_CTRL 8'h00
`define TPM_OFF_PERIOD 8'h04
`define TPM_OFF_LIMIT 8'h08
`define TPM_OFF_CUR1 8'h0C
`define TPM_OFF_CUR2 8'h10
`define TPM_OFF_AVG1 8'h14
`define TPM_OFF_AVG2 8'h18
`define TPM_OFF_STAT1 8'h1C
`define TPM_OFF_STAT2 8'h20
`define TPM_OFF_OVR 8'h24

// Control register fields
`define TPM_CTRL_SHORT 0
`define TPM_CTRL_HOTDIS 1
`define TPM_CTRL_SLEEP_LSB 4
`define TPM_CTRL_SLEEP_MSB 5

// Override register fields
`define TPM_OVR_EN 0
`define TPM_OVR_SEL 1
`define TPM_OVR_DUTY_LSB 8
`define TPM_OVR_DUTY_MSB 15

// Reset values
`define TPM_PERIOD_RST 16'h00FF
`define TPM_LIMIT_RST 8'hFF

// Measurement constants
`define TPM_COUNT_MAX 8'hFF
`define TPM_LAST_SAMPLE 8'hFF
`define TPM_TH_75 8'hC1
`define TPM_TH_50 8'h81
`define TPM_TH_25 8'h41
`define TPM_TH_12 8'h21

// Status flag positions
`define TPM_FLAG_FULL 0
`define TPM_FLAG_R75 1
`define TPM_FLAG_R50 2
`define TPM_FLAG_R25 3
`define TPM_FLAG_R12 4
`define TPM_FLAG_R0 5
`define TPM_FLAG_NZ 6
`define TPM_FLAG_USER 7

// Timing
`define TPM_CLK_PERIOD_NS 50
`define TPM_HOT_RESP_NS 10000
`define TPM_RESET_RESP_NS 10000

`endif

// File: inc/throttle_pkg.sv
package throttle_pkg;

   typedef enum logic [1:0] {
      awake_state,
      suspend_state,
      off_state
   } sleep_state_t;

   typedef logic [7:0] grade_flags_t;

endpackage : throttle_pkg

// File: core/throttle_channel.sv
`timescale 1ns/1ps
`include "throttle_defines.svh"

module throttle_channel
   import throttle_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control from the sequencer
   input wire logic active,
   input wire logic restart,
   input wire logic sample_tick,
   input wire logic interval_end,
   input wire logic asserted,
   input wire logic [7:0] user_limit,
   // Results
   output logic [7:0] cur_value,
   output logic [7:0] avg_value,
   output grade_flags_t flags
);

   typedef struct packed {
      logic [7:0] cnt;
      logic seen;
      logic all_on;
      logic first;
      logic [7:0] cur;
      logic [7:0] avg;
      grade_flags_t flags;
   } chan_state_t;

   chan_state_t st_reg;
   chan_state_t st_next;

   function automatic grade_flags_t grade(input logic [7:0] v, input logic full,
                                          input logic [7:0] lim);
      grade_flags_t f;
      f = '0;
      f[`TPM_FLAG_FULL] = full;
      f[`TPM_FLAG_R75] = (v >= `TPM_TH_75) && !full;
      f[`TPM_FLAG_R50] = (v >= `TPM_TH_50) && (v < `TPM_TH_75);
      f[`TPM_FLAG_R25] = (v >= `TPM_TH_25) && (v < `TPM_TH_50);
      f[`TPM_FLAG_R12] = (v >= `TPM_TH_12) && (v < `TPM_TH_25);
      f[`TPM_FLAG_R0] = (v != 8'h00) && (v < `TPM_TH_12);
      f[`TPM_FLAG_NZ] = (v != 8'h00);
      f[`TPM_FLAG_USER] = (v > lim);
      return f;
   endfunction : grade

   logic [8:0] h_sum;
   logic [7:0] h_half;
   assign h_sum = {1'b0, st_reg.avg} + {1'b0, st_reg.cur};
   assign h_half = h_sum[8:1];

   always_comb begin
      logic [7:0] res;
      res = 8'h00;
      st_next = st_reg;
      if (!active) begin
         // Sleep: counting halted, current cleared, average kept
         st_next.cnt = 8'h00;
         st_next.seen = 1'b0;
         st_next.all_on = 1'b1;
         st_next.first = 1'b1;
         st_next.cur = 8'h00;
         st_next.flags = '0;
      end else if (restart) begin
         st_next.cnt = 8'h00;
         st_next.seen = 1'b0;
         st_next.all_on = 1'b1;
      end else begin
         if (asserted) begin
            st_next.seen = 1'b1;
         end else begin
            st_next.all_on = 1'b0;
         end
         if (sample_tick && asserted && st_reg.cnt != `TPM_COUNT_MAX) begin
            st_next.cnt = st_reg.cnt + 8'h01;
         end
         if (interval_end) begin
            res = st_next.cnt;
            // Catches pulses that fell between two sample points
            if (st_next.seen && res == 8'h00) begin
               res = 8'h01;
            end
            st_next.cur = res;
            st_next.avg = st_reg.first ? res : h_half;
            st_next.first = 1'b0;
            st_next.flags = grade(res, st_next.all_on, user_limit);
            st_next.cnt = 8'h00;
            st_next.seen = 1'b0;
            st_next.all_on = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '{cnt: 8'h00, seen: 1'b0, all_on: 1'b1, first: 1'b1,
                     cur: 8'h00, avg: 8'h00, flags: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign cur_value = st_reg.cur;
   assign avg_value = st_reg.avg;
   assign flags = st_reg.flags;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_sleep_clear;
      !active |=> (cur_value == 8'h00) && (avg_value == $past(avg_value));
   endproperty
   a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear");

   property p_average;
      (active && !restart && interval_end && !st_reg.first) |=> avg_value == $past(h_half);
   endproperty
   a_average: assert property (p_average) else $error("average wrong");

   property p_first_direct;
      (active && !restart && interval_end && st_reg.first) |=> avg_value == cur_value;
   endproperty
   a_first_direct: assert property (p_first_direct) else $error("first not direct");

   property p_any_assert;
      (active && !restart && interval_end && asserted) |=> cur_value != 8'h00;
   endproperty
   a_any_assert: assert property (p_any_assert) else $error("assertion lost");

   property p_full_value;
      flags[`TPM_FLAG_FULL] |-> cur_value == `TPM_COUNT_MAX;
   endproperty
   a_full_value: assert property (p_full_value) else $error("full flag w/o max");

   property p_range50;
      flags[`TPM_FLAG_R50] |-> (cur_value >= `TPM_TH_50) && (cur_value < `TPM_TH_75);
   endproperty
   a_range50: assert property (p_range50) else $error("range 50 wrong");

   property p_range0;
      flags[`TPM_FLAG_R0] |-> (cur_value != 8'h00) && (cur_value < `TPM_TH_12);
   endproperty
   a_range0: assert property (p_range0) else $error("range 0 wrong");

   property p_nonzero;
      flags[`TPM_FLAG_NZ] == (cur_value != 8'h00);
   endproperty
   a_nonzero: assert property (p_nonzero) else $error("nonzero flag wrong");

endmodule : throttle_channel

// File: core/processor_throttle_monitor.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "throttle_defines.svh"

// Notes on behaviour
// - Each channel measures asserted fraction of an interval, 8 bits, step 1/256.
// - Interval end loads the new measurement into the current register.
// - Interval end sets average to half of old average plus old current.
// - Writing either current register restarts capture on both channels.
// - Zero means never asserted; any assertion gives at least one.
// - Full flag when the line never released during the interval.
// - Range flags for 193 and up (not full) and 129 to 192.
// - Range flags for 65-128, 33-64 and 1-32.
// - Nonzero flag, and user flag when result exceeds programmed limit.
// - Both lines measured independently with own registers and flags.
// - Suspend and off stop monitoring, clear current, keep average.
// - After wake, first result goes straight to current and average.
// - Short-together: external assertion of one line is mirrored onto the other.
// - Regulator overtemp asserts matching line within 10 us, releases after.
// - Short-together: either regulator overtemp asserts both lines.
// - Overtemp response off in suspend/off states or by disable bit.
// - Override drives PWM pattern on selected line, both if shorted.
// - External reset forces off state within 10 us.

module processor_throttle_monitor
   import throttle_pkg::*;
#(
   parameter int PERIOD_W = 16
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor throttle lines, open drain, active low
   input wire logic cpu1_throttle_line_in,
   output logic cpu1_throttle_line_out,
   output logic cpu1_throttle_line_oe_n,
   input wire logic cpu2_throttle_line_in,
   output logic cpu2_throttle_line_out,
   output logic cpu2_throttle_line_oe_n,
   // Regulator overtemperature, active high
   input wire logic regulator1_overtemp_in,
   input wire logic regulator2_overtemp_in,
   // System reset pin
   input wire logic ext_reset_n
);

   localparam int HOT_RESP_CYC = `TPM_HOT_RESP_NS / `TPM_CLK_PERIOD_NS;
   localparam int RESET_RESP_CYC = `TPM_RESET_RESP_NS / `TPM_CLK_PERIOD_NS;

   typedef struct packed {
      logic [1:0] s_line1;
      logic [1:0] s_line2;
      logic [1:0] s_hot1;
      logic [1:0] s_hot2;
      logic [1:0] s_rst;
      logic short_en;
      logic hot_dis;
      sleep_state_t sleep;
      logic [PERIOD_W-1:0] period;
      logic [7:0] limit;
      logic ovr_en;
      logic ovr_sel;
      logic [7:0] duty;
      logic [PERIOD_W-1:0] div;
      logic [7:0] idx;
      logic [7:0] pwm;
      logic [2:0] hist1;
      logic [2:0] hist2;
      logic oe1_n;
      logic oe2_n;
      logic restart;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } top_state_t;

   top_state_t st_reg;
   top_state_t st_next;

   logic active;
   logic tick_raw;
   logic sample_tick;
   logic interval_end;
   logic line1_low;
   logic line2_low;
   logic [7:0] cur1;
   logic [7:0] cur2;
   logic [7:0] avg1;
   logic [7:0] avg2;
   grade_flags_t flags1;
   grade_flags_t flags2;

   assign active = (st_reg.sleep == awake_state);
   assign line1_low = !st_reg.s_line1[1];
   assign line2_low = !st_reg.s_line2[1];
   assign tick_raw = (st_reg.div == st_reg.period);
   assign sample_tick = tick_raw && active && !st_reg.restart;
   assign interval_end = sample_tick && (st_reg.idx == `TPM_LAST_SAMPLE);

   always_comb begin
      logic access;
      logic done;
      logic hit;
      logic [31:0] rd;
      logic hot_ok;
      logic ext1;
      logic ext2;
      logic pwm_on;
      logic drive1;
      logic drive2;
      access = psel && penable;
      done = access && st_reg.ready;
      hit = 1'b1;
      rd = 32'h0000_0000;
      hot_ok = active && !st_reg.hot_dis;
      ext1 = line1_low && (st_reg.hist1 == 3'h0) && st_reg.oe1_n;
      ext2 = line2_low && (st_reg.hist2 == 3'h0) && st_reg.oe2_n;
      pwm_on = st_reg.ovr_en && (st_reg.pwm < st_reg.duty);
      drive1 = 1'b0;
      drive2 = 1'b0;
      st_next = st_reg;

      // Pin synchronisers
      st_next.s_line1 = {st_reg.s_line1[0], cpu1_throttle_line_in};
      st_next.s_line2 = {st_reg.s_line2[0], cpu2_throttle_line_in};
      st_next.s_hot1 = {st_reg.s_hot1[0], regulator1_overtemp_in};
      st_next.s_hot2 = {st_reg.s_hot2[0], regulator2_overtemp_in};
      st_next.s_rst = {st_reg.s_rst[0], ext_reset_n};

      // Sample timing, shared by both channels so they restart together
      if (st_reg.restart || tick_raw) begin
         st_next.div = '0;
      end else begin
         st_next.div = st_reg.div + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end
      if (tick_raw) begin
         st_next.pwm = st_reg.pwm + 8'h01;
      end
      if (!active || st_reg.restart) begin
         st_next.idx = 8'h00;
      end else if (sample_tick) begin
         st_next.idx = st_reg.idx + 8'h01;
      end

      // Register read decode
      if (paddr == `TPM_OFF_CTRL) begin
         rd[`TPM_CTRL_SHORT] = st_reg.short_en;
         rd[`TPM_CTRL_HOTDIS] = st_reg.hot_dis;
         rd[`TPM_CTRL_SLEEP_MSB:`TPM_CTRL_SLEEP_LSB] = st_reg.sleep;
      end else if (paddr == `TPM_OFF_PERIOD) begin
         rd[PERIOD_W-1:0] = st_reg.period;
      end else if (paddr == `TPM_OFF_LIMIT) begin
         rd[7:0] = st_reg.limit;
      end else if (paddr == `TPM_OFF_CUR1) begin
         rd[7:0] = cur1;
      end else if (paddr == `TPM_OFF_CUR2) begin
         rd[7:0] = cur2;
      end else if (paddr == `TPM_OFF_AVG1) begin
         rd[7:0] = avg1;
      end else if (paddr == `TPM_OFF_AVG2) begin
         rd[7:0] = avg2;
      end else if (paddr == `TPM_OFF_STAT1) begin
         rd[7:0] = flags1;
      end else if (paddr == `TPM_OFF_STAT2) begin
         rd[7:0] = flags2;
      end else if (paddr == `TPM_OFF_OVR) begin
         rd[`TPM_OVR_EN] = st_reg.ovr_en;
         rd[`TPM_OVR_SEL] = st_reg.ovr_sel;
         rd[`TPM_OVR_DUTY_MSB:`TPM_OVR_DUTY_LSB] = st_reg.duty;
      end else begin
         hit = 1'b0;
      end

      // One wait state: answer registered in the first access cycle
      st_next.ready = access && !st_reg.ready;
      st_next.err = access && !st_reg.ready && !hit;
      st_next.rdata = (access && !st_reg.ready) ? rd : 32'h0000_0000;
      st_next.restart = 1'b0;

      if (done && pwrite && !st_reg.err) begin
         if (paddr == `TPM_OFF_CTRL) begin
            st_next.short_en = pwdata[`TPM_CTRL_SHORT];
            st_next.hot_dis = pwdata[`TPM_CTRL_HOTDIS];
            if (pwdata[`TPM_CTRL_SLEEP_MSB:`TPM_CTRL_SLEEP_LSB] == 2'h0) begin
               st_next.sleep = awake_state;
            end else if (pwdata[`TPM_CTRL_SLEEP_MSB:`TPM_CTRL_SLEEP_LSB] == 2'h1) begin
               st_next.sleep = suspend_state;
            end else begin
               st_next.sleep = off_state;
            end
         end else if (paddr == `TPM_OFF_PERIOD) begin
            st_next.period = pwdata[PERIOD_W-1:0];
            st_next.restart = 1'b1;
         end else if (paddr == `TPM_OFF_LIMIT) begin
            st_next.limit = pwdata[7:0];
         end else if (paddr == `TPM_OFF_CUR1 || paddr == `TPM_OFF_CUR2) begin
            st_next.restart = 1'b1;
         end else if (paddr == `TPM_OFF_OVR) begin
            st_next.ovr_en = pwdata[`TPM_OVR_EN];
            st_next.ovr_sel = pwdata[`TPM_OVR_SEL];
            st_next.duty = pwdata[`TPM_OVR_DUTY_MSB:`TPM_OVR_DUTY_LSB];
         end
      end

      // Reset pin wins over any software write to the sleep field
      if (!st_reg.s_rst[1]) begin
         st_next.sleep = off_state;
      end

      // Line drive; our own recent drive is masked so a mirror cannot latch
      if (hot_ok && (st_reg.s_hot1[1] || (st_reg.short_en && st_reg.s_hot2[1]))) begin
         drive1 = 1'b1;
      end
      if (hot_ok && (st_reg.s_hot2[1] || (st_reg.short_en && st_reg.s_hot1[1]))) begin
         drive2 = 1'b1;
      end
      if (st_reg.short_en && ext2) begin
         drive1 = 1'b1;
      end
      if (st_reg.short_en && ext1) begin
         drive2 = 1'b1;
      end
      if (pwm_on && (!st_reg.ovr_sel || st_reg.short_en)) begin
         drive1 = 1'b1;
      end
      if (pwm_on && (st_reg.ovr_sel || st_reg.short_en)) begin
         drive2 = 1'b1;
      end
      st_next.oe1_n = !drive1;
      st_next.oe2_n = !drive2;
      st_next.hist1 = {st_reg.hist1[1:0], !st_reg.oe1_n};
      st_next.hist2 = {st_reg.hist2[1:0], !st_reg.oe2_n};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '{s_line1: 2'h3, s_line2: 2'h3, s_hot1: 2'h0, s_hot2: 2'h0,
                     s_rst: 2'h3, short_en: 1'b0, hot_dis: 1'b0, sleep: awake_state,
                     period: PERIOD_W'(`TPM_PERIOD_RST), limit: `TPM_LIMIT_RST, ovr_en: 1'b0,
                     ovr_sel: 1'b0, duty: 8'h00, div: '0, idx: 8'h00, pwm: 8'h00,
                     hist1: 3'h0, hist2: 3'h0, oe1_n: 1'b1, oe2_n: 1'b1,
                     restart: 1'b0, rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // Independent channels with their own results and flags
   throttle_channel u_chan1 (
      .pclk(pclk),
      .presetn(presetn),
      .active(active),
      .restart(st_reg.restart),
      .sample_tick(sample_tick),
      .interval_end(interval_end),
      .asserted(line1_low),
      .user_limit(st_reg.limit),
      .cur_value(cur1),
      .avg_value(avg1),
      .flags(flags1)
   );

   throttle_channel u_chan2 (
      .pclk(pclk),
      .presetn(presetn),
      .active(active),
      .restart(st_reg.restart),
      .sample_tick(sample_tick),
      .interval_end(interval_end),
      .asserted(line2_low),
      .user_limit(st_reg.limit),
      .cur_value(cur2),
      .avg_value(avg2),
      .flags(flags2)
   );

   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.err;
   // Open drain: the pad only ever pulls low
   assign cpu1_throttle_line_out = 1'b0;
   assign cpu2_throttle_line_out = 1'b0;
   assign cpu1_throttle_line_oe_n = st_reg.oe1_n;
   assign cpu2_throttle_line_oe_n = st_reg.oe2_n;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_hot_resp;
      (regulator1_overtemp_in && active && !st_reg.hot_dis)[*3]
         |-> ##[1:HOT_RESP_CYC] !cpu1_throttle_line_oe_n;
   endproperty
   a_hot_resp: assert property (p_hot_resp) else $error("overtemp response late");

   property p_short_hot;
      (st_reg.s_hot2[1] && st_reg.short_en && active && !st_reg.hot_dis)
         |=> !cpu1_throttle_line_oe_n && !cpu2_throttle_line_oe_n;
   endproperty
   a_short_hot: assert property (p_short_hot) else $error("short overtemp missed");

   property p_sleep_mask;
      (!active && !st_reg.ovr_en && !st_reg.short_en)
         |=> cpu1_throttle_line_oe_n && cpu2_throttle_line_oe_n;
   endproperty
   a_sleep_mask: assert property (p_sleep_mask) else $error("drive in sleep");

   property p_reset_force;
      (!ext_reset_n)[*3] |-> ##[1:RESET_RESP_CYC] (st_reg.sleep == off_state);
   endproperty
   a_reset_force: assert property (p_reset_force) else $error("reset not forced");

   property p_restart;
      (psel && penable && pready && pwrite && !pslverr && paddr == `TPM_OFF_CUR2)
         |=> st_reg.restart ##1 (st_reg.idx == 8'h00 && st_reg.div == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("restart missing");

   property p_mirror;
      (st_reg.short_en && line2_low && st_reg.hist2 == 3'h0 && st_reg.oe2_n)
         |=> !cpu1_throttle_line_oe_n;
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror missing");

   property p_override;
      (st_reg.ovr_en && !st_reg.ovr_sel && st_reg.pwm < st_reg.duty)
         |=> !cpu1_throttle_line_oe_n;
   endproperty
   a_override: assert property (p_override) else $error("override missing");

   property p_apb_answer;
      (psel && penable && !pready) |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("no apb answer");

endmodule : processor_throttle_monitor

// File: test/cpu_side_model.sv
`timescale 1ns/1ps
module cpu_side_model (
   // Device side of the open-drain pins
   input wire logic cpu1_oe_n,
   input wire logic cpu1_out,
   input wire logic cpu2_oe_n,
   input wire logic cpu2_out,
   // Processor pulls, high = processor asserts
   input wire logic cpu1_pull,
   input wire logic cpu2_pull,
   // Wired levels
   output logic cpu1_level,
   output logic cpu2_level
);
   // Board pull-up takes the line high once every driver lets go
   assign cpu1_level = ~cpu1_pull & (cpu1_oe_n | cpu1_out);
   assign cpu2_level = ~cpu2_pull & (cpu2_oe_n | cpu2_out);
endmodule : cpu_side_model

// File: test/processor_throttle_monitor_tb.sv
`timescale 1ns/1ps
`include "throttle_defines.svh"
module processor_throttle_monitor_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_reset_n, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic oe1, out1, oe2, out2, lv1, lv2, p1, p2, h1, h2;
   int mismatches, samples_checked, cyc;

   processor_throttle_monitor DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu1_throttle_line_in(lv1), .cpu1_throttle_line_out(out1),
      .cpu1_throttle_line_oe_n(oe1), .cpu2_throttle_line_in(lv2),
      .cpu2_throttle_line_out(out2), .cpu2_throttle_line_oe_n(oe2),
      .regulator1_overtemp_in(h1), .regulator2_overtemp_in(h2),
      .ext_reset_n(ext_reset_n));
   cpu_side_model cpus (.cpu1_oe_n(oe1), .cpu1_out(out1), .cpu2_oe_n(oe2),
      .cpu2_out(out2), .cpu1_pull(p1), .cpu2_pull(p2), .cpu1_level(lv1),
      .cpu2_level(lv2));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   // Idle edge first, so a strobe is never dropped and raised in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rdc

   // Waits at most 200 cycles, the 10 us response bound
   task automatic oe(input string what, input logic [1:0] exp);
      int n;
      n = 0;
      while ({oe1, oe2} !== exp && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk(what, 32'(exp), 32'({oe1, oe2}));
   endtask : oe

   function automatic logic [7:0] grade(input logic [7:0] d);
      return {d > 8'h80, d != 8'h0, d != 8'h0 && d < 8'h21, d >= 8'h21 && d < 8'h41,
         d >= 8'h41 && d < 8'h81, d >= 8'h81 && d < 8'hC1, d >= 8'hC1, 1'b0};
   endfunction : grade

   task automatic t_measure();
      rdc("period", `TPM_OFF_PERIOD, 32'hFF);
      rdc("limit", `TPM_OFF_LIMIT, 32'hFF);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped err", 32'h1, 32'(err));
      apb(1'b1, `TPM_OFF_PERIOD, 32'h0);
      p1 <= 1'b1;
      apb(1'b1, `TPM_OFF_CUR1, 32'h0);
      wt(266);
      rdc("cur1", `TPM_OFF_CUR1, 32'hFF);
      rdc("avg1", `TPM_OFF_AVG1, 32'hFF);
      rdc("stat1", `TPM_OFF_STAT1, 32'h41);
      rdc("cur2", `TPM_OFF_CUR2, 32'h0);
      rdc("stat2", `TPM_OFF_STAT2, 32'h0);
      p1 <= 1'b0;
      wt(5);
      apb(1'b1, `TPM_OFF_CUR2, 32'h0);
      wt(266);
      rdc("cur1", `TPM_OFF_CUR1, 32'h0);
      rdc("avg1", `TPM_OFF_AVG1, 32'hFF);
      wt(256);
      rdc("avg1", `TPM_OFF_AVG1, 32'h7F);
      $display("test measure done");
   endtask : t_measure

   task automatic t_sleep();
      apb(1'b1, `TPM_OFF_CTRL, 32'h10);
      wt(20);
      rdc("cur1 asleep", `TPM_OFF_CUR1, 32'h0);
      p1 <= 1'b1;
      apb(1'b1, `TPM_OFF_CTRL, 32'h0);
      wt(266);
      rdc("cur1 wake", `TPM_OFF_CUR1, 32'hFF);
      rdc("avg1 wake", `TPM_OFF_AVG1, 32'hFF);
      apb(1'b1, `TPM_OFF_CTRL, 32'h10);
      h1 <= 1'b1;
      wt(600);
      oe("hot asleep", 2'b11);
      rdc("cur1 asleep", `TPM_OFF_CUR1, 32'h0);
      rdc("avg1 held", `TPM_OFF_AVG1, 32'hFF);
      h1 <= 1'b0;
      p1 <= 1'b0;
      ext_reset_n <= 1'b0;
      apb(1'b1, `TPM_OFF_CTRL, 32'h0);
      wt(6);
      rdc("ctrl forced", `TPM_OFF_CTRL, 32'h20);
      ext_reset_n <= 1'b1;
      wt(4);
      apb(1'b1, `TPM_OFF_CTRL, 32'h31);
      rdc("ctrl off", `TPM_OFF_CTRL, 32'h21);
      apb(1'b1, `TPM_OFF_CTRL, 32'h0);
      rdc("ctrl awake", `TPM_OFF_CTRL, 32'h0);
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_grade();
      logic [7:0] duty [10] = '{8'h01, 8'h20, 8'h21, 8'h40, 8'h41, 8'h80, 8'h81,
         8'hC0, 8'hC1, 8'hFF};
      apb(1'b1, `TPM_OFF_LIMIT, 32'h80);
      foreach (duty[i]) begin
         apb(1'b1, `TPM_OFF_OVR, {16'h0, duty[i], 8'h01});
         apb(1'b1, `TPM_OFF_CUR1, 32'h0);
         wt(266);
         rdc("cur1", `TPM_OFF_CUR1, {24'h0, duty[i]});
         rdc("stat1", `TPM_OFF_STAT1, {24'h0, grade(duty[i])});
      end
      apb(1'b1, `TPM_OFF_OVR, 32'h4003);
      apb(1'b1, `TPM_OFF_CUR1, 32'h0);
      wt(266);
      rdc("cur2 sel", `TPM_OFF_CUR2, 32'h40);
      rdc("cur1 sel", `TPM_OFF_CUR1, 32'h0);
      apb(1'b1, `TPM_OFF_CTRL, 32'h1);
      apb(1'b1, `TPM_OFF_OVR, 32'h4001);
      apb(1'b1, `TPM_OFF_CUR1, 32'h0);
      wt(266);
      rdc("cur2 short", `TPM_OFF_CUR2, 32'h40);
      apb(1'b1, `TPM_OFF_OVR, 32'h0);
      apb(1'b1, `TPM_OFF_CTRL, 32'h0);
      $display("test grade done");
   endtask : t_grade

   task automatic t_lines();
      wt(300);
      h1 <= 1'b1;
      oe("hot1", 2'b01);
      chk("line out", 32'h0, 32'({out1, out2}));
      h1 <= 1'b0;
      oe("hot1 off", 2'b11);
      apb(1'b1, `TPM_OFF_CTRL, 32'h1);
      h2 <= 1'b1;
      oe("hot2 short", 2'b00);
      h2 <= 1'b0;
      oe("hot2 off", 2'b11);
      p1 <= 1'b1;
      oe("mirror", 2'b10);
      p1 <= 1'b0;
      oe("mirror off", 2'b11);
      p2 <= 1'b1;
      oe("mirror back", 2'b01);
      p2 <= 1'b0;
      oe("mirror back off", 2'b11);
      apb(1'b1, `TPM_OFF_CTRL, 32'h2);
      h1 <= 1'b1;
      wt(20);
      oe("hot disabled", 2'b11);
      h1 <= 1'b0;
      $display("test lines done");
   endtask : t_lines

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      p1 = 1'b0;
      p2 = 1'b0;
      h1 = 1'b0;
      h2 = 1'b0;
      ext_reset_n = 1'b1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctrl", `TPM_OFF_CTRL, 32'h0);
      t_measure();
      t_sleep();
      t_grade();
      t_lines();
      wrap_up();
   end
endmodule : processor_throttle_monitor_tb
